// ### lp4_pd_sequencer.v
// Host-side sequencer for power-down entry/exit and mode register command spacing
//
// Operation
// - Hold clock enable at each level at least max(7.5 ns, 4 cycles).
// - Wait command-to-enable-low delay after a valid command before enable low.
// - Keep clock toggling max(5 ns, 5 cycles) after enable falls.
// - Keep chip select valid at least 1.75 ns before enable falls.
// - Keep chip select valid max(5 ns, 5 cycles) after enable falls.
// - Restart clock max(1.75 ns, 3 cycles) before raising enable.
// - No valid command until max(7.5 ns, 5 cycles) after power-down exit.
// - Chip select valid 1.75 ns before and max(7.5 ns, 5 cycles) after enable rises.
// - After mode write, hold clock and select max(14 ns, 10 cycles) past enable low.
// - After calibration start, hold clock and select their interval past enable low.
// - Space mode write from next command by max(10 ns, 10 cycles).
// - Space mode read from next command by the read command period.
// - Mode read waits exit delay plus row-to-column delay plus cycles.
`include "lp4_pd_regs.vh"

module lp4_pd_sequencer (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // User requests
    input wire pd_req_i,
    input wire cmd_valid_i,
    input wire [1:0] cmd_type_i,
    // User status
    output wire cmd_ready_o,
    output wire pd_active_o,
    // Memory side pins
    output wire cke_o,
    output wire cs_o,
    output wire cs_oe_o,
    output wire ck_run_o,
    output wire [1:0] cmd_o
);
    // One-hot states
    localparam [4:0] ST_ACT = 5'h01;
    localparam [4:0] ST_HOLD = 5'h02;
    localparam [4:0] ST_PD = 5'h04;
    localparam [4:0] ST_SETUP = 5'h08;
    localparam [4:0] ST_EXIT = 5'h10;

    // Cycle counts, derived from time and cycle figures in the header
    localparam integer CKE_PULSE_INT = `CKE_PULSE_CYC;
    localparam integer CMD_CKE_INT = `CMD_CKE_CYC;
    localparam integer CK_HOLD_INT = `CK_HOLD_CYC;
    localparam integer CS_HOLD_LOW_INT = `CS_HOLD_LOW_CYC;
    localparam integer CK_SETUP_HIGH_INT = `CK_SETUP_HIGH_CYC;
    localparam integer CS_SETUP_HIGH_INT = `CS_SETUP_HIGH_CYC;
    localparam integer XP_INT = `XP_CYC;
    localparam integer CS_HOLD_HIGH_INT = `CS_HOLD_HIGH_CYC;
    localparam integer MRW_HOLD_INT = `MRW_HOLD_CYC;
    localparam integer ZQ_HOLD_INT = `ZQ_HOLD_CYC;
    localparam integer MRW_PERIOD_INT = `MRW_PERIOD_CYC;
    localparam integer MRR_PERIOD_INT = `MRR_PERIOD_CYC;
    localparam integer OTHER_PERIOD_INT = `OTHER_PERIOD_CYC;
    localparam integer MRRI_INT = `MRRI_CYC;
    // Cut to the 8-bit timer width; every count is far below 256
    localparam [7:0] CKE_PULSE = CKE_PULSE_INT[7:0];
    localparam [7:0] CMD_CKE = CMD_CKE_INT[7:0];
    localparam [7:0] CK_HOLD = CK_HOLD_INT[7:0];
    localparam [7:0] CS_HOLD_LOW = CS_HOLD_LOW_INT[7:0];
    localparam [7:0] CK_SETUP_HIGH = CK_SETUP_HIGH_INT[7:0];
    localparam [7:0] CS_SETUP_HIGH = CS_SETUP_HIGH_INT[7:0];
    localparam [7:0] XP = XP_INT[7:0];
    localparam [7:0] CS_HOLD_HIGH = CS_HOLD_HIGH_INT[7:0];
    localparam [7:0] MRW_HOLD = MRW_HOLD_INT[7:0];
    localparam [7:0] ZQ_HOLD = ZQ_HOLD_INT[7:0];
    localparam [7:0] MRW_PERIOD = MRW_PERIOD_INT[7:0];
    localparam [7:0] MRR_PERIOD = MRR_PERIOD_INT[7:0];
    localparam [7:0] OTHER_PERIOD = OTHER_PERIOD_INT[7:0];
    localparam [7:0] MRRI = MRRI_INT[7:0];

    // Combined windows: the larger of the figures that run together; the mode read wait is the sum of XP and MRRI
    localparam [7:0] PD_HOLD_BASE = (CK_HOLD > CS_HOLD_LOW) ? CK_HOLD : CS_HOLD_LOW;
    localparam [7:0] EXIT_SETUP = (CK_SETUP_HIGH > CS_SETUP_HIGH) ? CK_SETUP_HIGH
        : CS_SETUP_HIGH;
    localparam [7:0] EXIT_WAIT = (XP > CS_HOLD_HIGH) ? XP : CS_HOLD_HIGH;
    localparam [7:0] MRR_WAIT = XP + MRRI;

    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg cke_r;
    reg cke_nxt;
    reg cs_r;
    reg cs_nxt;
    reg cs_oe_r;
    reg cs_oe_nxt;
    reg ck_run_r;
    reg ck_run_nxt;
    reg [1:0] cmd_r;
    reg [1:0] cmd_nxt;
    reg ready_r;
    reg ready_nxt;
    reg last_mrw_r;
    reg last_mrw_nxt;
    reg last_zq_r;
    reg last_zq_nxt;

    // Timer controls
    reg cke_ld;
    reg cmdcke_ld;
    reg space_ld;
    reg [7:0] space_val;
    reg seq_ld;
    reg [7:0] seq_val;
    reg mrri_ld;
    wire cke_busy;
    wire cmdcke_busy;
    wire space_busy;
    wire seq_busy;
    wire mrri_busy;

    wire accept = cmd_valid_i & ready_r;

    // Time since the last enable edge
    hold_timer u_cke (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(cke_ld),
        .value_i(CKE_PULSE),
        .busy_o(cke_busy)
    );

    // Time since the last command, gating enable low
    hold_timer u_cmdcke (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(cmdcke_ld),
        .value_i(CMD_CKE),
        .busy_o(cmdcke_busy)
    );

    // Command-to-command spacing
    hold_timer u_space (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(space_ld),
        .value_i(space_val),
        .busy_o(space_busy)
    );

    // Entry hold, exit setup and exit wait run one after another
    hold_timer u_seq (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(seq_ld),
        .value_i(seq_val),
        .busy_o(seq_busy)
    );

    // Lockout of every command after exit, sized for a mode read
    hold_timer u_mrri (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(mrri_ld),
        .value_i(MRR_WAIT),
        .busy_o(mrri_busy)
    );

    // Spacing after each command kind
    always @* begin
        case (cmd_type_i)
            `CMD_MRW: space_val = MRW_PERIOD;
            `CMD_MRR: space_val = MRR_PERIOD;
            default: space_val = OTHER_PERIOD;
        endcase
    end

    // Sequencer next state
    always @* begin
        state_nxt = state_r;
        cke_nxt = cke_r;
        cs_nxt = 1'b0;
        cs_oe_nxt = cs_oe_r;
        ck_run_nxt = ck_run_r;
        cmd_nxt = cmd_r;
        last_mrw_nxt = last_mrw_r;
        last_zq_nxt = last_zq_r;
        cke_ld = 1'b0;
        cmdcke_ld = 1'b0;
        space_ld = 1'b0;
        seq_ld = 1'b0;
        seq_val = 8'h00;
        mrri_ld = 1'b0;
        case (state_r)
            ST_ACT: begin
                if (accept) begin
                    cs_nxt = 1'b1;
                    cmd_nxt = cmd_type_i;
                    space_ld = 1'b1;
                    cmdcke_ld = 1'b1;
                    last_mrw_nxt = (cmd_type_i == `CMD_MRW);
                    last_zq_nxt = (cmd_type_i == `CMD_ZQS);
                end else if (pd_req_i && !cke_busy && !cmdcke_busy && !space_busy
                             && cs_oe_r) begin
                    cke_nxt = 1'b0;
                    cke_ld = 1'b1;
                    seq_ld = 1'b1;
                    // Clock and select stay valid for the longest applicable hold
                    if (last_mrw_r && MRW_HOLD > PD_HOLD_BASE) begin
                        seq_val = MRW_HOLD;
                    end else if (last_zq_r && ZQ_HOLD > PD_HOLD_BASE) begin
                        seq_val = ZQ_HOLD;
                    end else begin
                        seq_val = PD_HOLD_BASE;
                    end
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!seq_busy) begin
                    ck_run_nxt = 1'b0;
                    cs_oe_nxt = 1'b0;
                    state_nxt = ST_PD;
                end
            end
            ST_PD: begin
                if (!pd_req_i && !cke_busy) begin
                    ck_run_nxt = 1'b1;
                    cs_oe_nxt = 1'b1;
                    seq_ld = 1'b1;
                    seq_val = EXIT_SETUP;
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (!seq_busy) begin
                    cke_nxt = 1'b1;
                    cke_ld = 1'b1;
                    seq_ld = 1'b1;
                    seq_val = EXIT_WAIT;
                    mrri_ld = 1'b1;
                    last_mrw_nxt = 1'b0;
                    last_zq_nxt = 1'b0;
                    state_nxt = ST_EXIT;
                end
            end
            ST_EXIT: begin
                if (!seq_busy) begin
                    state_nxt = ST_ACT;
                end
            end
            default: begin
                state_nxt = ST_ACT;
            end
        endcase
    end

    // Ready is registered; the accept term blocks a second take before spacing starts
    always @* begin
        ready_nxt = (state_nxt == ST_ACT) && !pd_req_i && !accept && !space_busy
            && !mrri_busy;
    end

    // Sequencer registers; after reset the device is awake with clock running
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_ACT;
            cke_r <= 1'b1;
            cs_r <= 1'b0;
            cs_oe_r <= 1'b1;
            ck_run_r <= 1'b1;
            cmd_r <= `CMD_OTHER;
            ready_r <= 1'b0;
            last_mrw_r <= 1'b0;
            last_zq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cke_r <= cke_nxt;
            cs_r <= cs_nxt;
            cs_oe_r <= cs_oe_nxt;
            ck_run_r <= ck_run_nxt;
            cmd_r <= cmd_nxt;
            ready_r <= ready_nxt;
            last_mrw_r <= last_mrw_nxt;
            last_zq_r <= last_zq_nxt;
        end
    end

    // Outputs straight from flops
    assign cmd_ready_o = ready_r;
    assign pd_active_o = state_r[2]; // One-hot bit of the power-down state
    assign cke_o = cke_r;
    assign cs_o = cs_r;
    assign cs_oe_o = cs_oe_r;
    assign ck_run_o = ck_run_r;
    assign cmd_o = cmd_r;
endmodule // lp4_pd_sequencer

// ### lp4_pd_regs.vh
// Timing constants for the power-down and mode register command sequencer
`ifndef LP4_PD_REGS_VH
`define LP4_PD_REGS_VH

// Controller clock period in picoseconds (20 MHz)
`define CLK_PERIOD_PS 50000

// Larger of a time rounded up to whole cycles and a cycle count
`define PS_UP(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MAX_CYC(ps, n) ((`PS_UP(ps) > (n)) ? `PS_UP(ps) : (n))

// Clock enable minimum pulse width, either level
`define CLOCK_ENABLE_MIN_PULSE_PS 7500
`define CLOCK_ENABLE_MIN_PULSE_NCK 4
// Valid command to clock enable low
`define COMMAND_TO_CLOCK_ENABLE_LOW_DELAY_PS 1750
`define COMMAND_TO_CLOCK_ENABLE_LOW_DELAY_NCK 3
// Clock held toggling after clock enable low
`define CLOCK_HOLD_AFTER_ENABLE_LOW_PS 5000
`define CLOCK_HOLD_AFTER_ENABLE_LOW_NCK 5
// Chip select valid before clock enable low
`define SELECT_SETUP_BEFORE_ENABLE_LOW_PS 1750
// Chip select valid after clock enable low
`define SELECT_HOLD_AFTER_ENABLE_LOW_PS 5000
`define SELECT_HOLD_AFTER_ENABLE_LOW_NCK 5
// Clock restarted before clock enable high
`define CLOCK_SETUP_BEFORE_ENABLE_HIGH_PS 1750
`define CLOCK_SETUP_BEFORE_ENABLE_HIGH_NCK 3
// Power-down exit to next valid command
`define POWERDOWN_EXIT_DELAY_PS 7500
`define POWERDOWN_EXIT_DELAY_NCK 5
// Chip select valid before and after clock enable high
`define SELECT_SETUP_BEFORE_ENABLE_HIGH_PS 1750
`define SELECT_HOLD_AFTER_ENABLE_HIGH_PS 7500
`define SELECT_HOLD_AFTER_ENABLE_HIGH_NCK 5
// Clock and chip select hold after enable low following mode write
`define MODEWRITE_ENABLE_LOW_HOLD_PS 14000
`define MODEWRITE_ENABLE_LOW_HOLD_NCK 10
// Clock and chip select hold after enable low following calibration start
`define CALIBRATION_ENABLE_LOW_HOLD_PS 1750
`define CALIBRATION_ENABLE_LOW_HOLD_NCK 3
// Mode register write and read command periods
`define MODE_WRITE_PERIOD_PS 10000
`define MODE_WRITE_PERIOD_NCK 10
`define MODE_READ_PERIOD_NCK 3
// Extra wait before a mode read after exit: row-to-column delay plus cycles
`define ROW_TO_COLUMN_DELAY_PS 18000
`define ROW_TO_COLUMN_DELAY_NCK 4
`define MODE_READ_AFTER_EXIT_EXTRA_NCK 3

// Cycle counts
`define CKE_PULSE_CYC `MAX_CYC(`CLOCK_ENABLE_MIN_PULSE_PS, `CLOCK_ENABLE_MIN_PULSE_NCK)
`define CMD_CKE_CYC `MAX_CYC(`COMMAND_TO_CLOCK_ENABLE_LOW_DELAY_PS, \
    `COMMAND_TO_CLOCK_ENABLE_LOW_DELAY_NCK)
`define CK_HOLD_CYC `MAX_CYC(`CLOCK_HOLD_AFTER_ENABLE_LOW_PS, `CLOCK_HOLD_AFTER_ENABLE_LOW_NCK)
`define CS_SETUP_LOW_CYC `MAX_CYC(`SELECT_SETUP_BEFORE_ENABLE_LOW_PS, 1)
`define CS_HOLD_LOW_CYC `MAX_CYC(`SELECT_HOLD_AFTER_ENABLE_LOW_PS, \
    `SELECT_HOLD_AFTER_ENABLE_LOW_NCK)
`define CK_SETUP_HIGH_CYC `MAX_CYC(`CLOCK_SETUP_BEFORE_ENABLE_HIGH_PS, \
    `CLOCK_SETUP_BEFORE_ENABLE_HIGH_NCK)
`define XP_CYC `MAX_CYC(`POWERDOWN_EXIT_DELAY_PS, `POWERDOWN_EXIT_DELAY_NCK)
`define CS_SETUP_HIGH_CYC `MAX_CYC(`SELECT_SETUP_BEFORE_ENABLE_HIGH_PS, 1)
`define CS_HOLD_HIGH_CYC `MAX_CYC(`SELECT_HOLD_AFTER_ENABLE_HIGH_PS, \
    `SELECT_HOLD_AFTER_ENABLE_HIGH_NCK)
`define MRW_HOLD_CYC `MAX_CYC(`MODEWRITE_ENABLE_LOW_HOLD_PS, `MODEWRITE_ENABLE_LOW_HOLD_NCK)
`define ZQ_HOLD_CYC `MAX_CYC(`CALIBRATION_ENABLE_LOW_HOLD_PS, `CALIBRATION_ENABLE_LOW_HOLD_NCK)
`define MRW_PERIOD_CYC `MAX_CYC(`MODE_WRITE_PERIOD_PS, `MODE_WRITE_PERIOD_NCK)
`define MRR_PERIOD_CYC `MODE_READ_PERIOD_NCK
`define MRRI_CYC (`MAX_CYC(`ROW_TO_COLUMN_DELAY_PS, `ROW_TO_COLUMN_DELAY_NCK) + \
    `MODE_READ_AFTER_EXIT_EXTRA_NCK)
`define OTHER_PERIOD_CYC 1

// Command codes on the command output
`define CMD_OTHER 2'h0
`define CMD_MRW 2'h1
`define CMD_MRR 2'h2
`define CMD_ZQS 2'h3

`endif

// ### hold_timer.v
// Reloadable down-counter that reports busy until a loaded count expires
module hold_timer (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Load request and count
    input wire load_i,
    input wire [7:0] value_i,
    // Count still running
    output wire busy_o
);
    reg [7:0] cnt_r;

    // Load wins over the decrement so a restart is never lost
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 8'h00;
        end else if (load_i) begin
            cnt_r <= value_i;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    assign busy_o = (cnt_r != 8'h00);
endmodule // hold_timer

// ### lp4_pd_sequencer_checker.sv
// Port assertions for the power-down and mode register sequencer
module lp4_pd_sequencer_checker (
    input wire mclk_i,
    input wire rst_n_i,
    input wire pd_req_i,
    input wire cmd_valid_i,
    input wire [1:0] cmd_type_i,
    input wire cmd_ready_o,
    input wire pd_active_o,
    input wire cke_o,
    input wire cs_o,
    input wire cs_oe_o,
    input wire ck_run_o,
    input wire [1:0] cmd_o
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // Last issued command was a mode write; it widens the entry hold
    logic last_mrw_r;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            last_mrw_r <= 1'b0;
        else if (cs_o)
            last_mrw_r <= (cmd_o == 2'h1);
        else if (!cke_o)
            last_mrw_r <= 1'b0; // Forgotten in power-down, as the design does on exit
    end

    cke_pulse_a: assert property ($changed(cke_o) |=> $stable(cke_o)[*3])
        else $error("enable level held too briefly");
    cmd_to_low_a: assert property ($fell(cke_o) |-> !$past(cs_o, 1) && !$past(cs_o, 2))
        else $error("enable fell too soon after a command");
    clk_hold_low_a: assert property ($fell(cke_o) |-> ck_run_o[*5])
        else $error("clock stopped too soon after enable fell");
    sel_hold_low_a: assert property ($fell(cke_o) |-> $past(cs_oe_o) ##0 cs_oe_o[*5])
        else $error("select not valid around enable fall");
    mrw_hold_a: assert property ($fell(cke_o) && last_mrw_r
        |-> (ck_run_o && cs_oe_o)[*8] ##1 (ck_run_o && cs_oe_o)[*2])
        else $error("mode write hold cut short");
    exit_setup_a: assert property ($rose(cke_o) |-> $past(ck_run_o, 3) && $past(cs_oe_o))
        else $error("clock or select not ready before enable rose");
    exit_wait_a: assert property ($rose(cke_o) |-> !cs_o[*8] ##1 !cs_o[*4])
        else $error("command issued too soon after exit");
    sel_hold_high_a: assert property ($rose(cke_o) |-> cs_oe_o[*5])
        else $error("select dropped after enable rose");
    mrw_space_a: assert property (cs_o && cmd_o == 2'h1 |=> !cs_o[*8] ##1 !cs_o)
        else $error("mode write spacing too short");
    mrr_space_a: assert property (cs_o && cmd_o == 2'h2 |=> !cs_o[*2])
        else $error("mode read spacing too short");

    // Main scenarios reached
    entry_c: cover property ($fell(cke_o) && last_mrw_r);
    exit_c: cover property ($rose(cke_o));
    mrr_c: cover property (cs_o && cmd_o == 2'h2);
endmodule // lp4_pd_sequencer_checker

bind lp4_pd_sequencer lp4_pd_sequencer_checker i_lp4_pd_sequencer_checker (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .pd_req_i(pd_req_i), .cmd_valid_i(cmd_valid_i),
    .cmd_type_i(cmd_type_i), .cmd_ready_o(cmd_ready_o), .pd_active_o(pd_active_o),
    .cke_o(cke_o), .cs_o(cs_o), .cs_oe_o(cs_oe_o), .ck_run_o(ck_run_o), .cmd_o(cmd_o));

// ### lp4_pd_device_model.sv
// Behavioural memory device seen from the sequencer's pins
module lp4_pd_device_model (
    input wire mclk_i,
    input wire rst_n_i,
    input wire cke_i,
    input wire cs_i,
    input wire cs_oe_i,
    input wire ck_run_i,
    input wire [1:0] cmd_i,
    output logic strobe_drv_o,
    output int err_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Device only sees edges while the clock runs; a command in power-down is illegal
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strobe_drv_o <= 1'b0;
            err_o <= 0;
        end else if (ck_run_i) begin
            if (cs_i && (!cke_i || !cs_oe_i))
                err_o <= err_o + 1;
            // Strobe driven one cycle after a mode write, well inside its limit
            if (cs_i)
                strobe_drv_o <= (cmd_i == 2'h1);
        end
    end
endmodule // lp4_pd_device_model

// ### dram_powerdown_mode_reg_timing_tb.sv
// Self-checking bench for the power-down and mode register sequencer
module dram_powerdown_mode_reg_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic pd_req_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_type_i = 2'h0;
    wire cmd_ready_o, pd_active_o, cke_o, cs_o, cs_oe_o, ck_run_o, strobe_drv;
    wire [1:0] cmd_o;
    int dev_err;
    int n_fail = 0;
    int check_count = 0;
    int n;
    // Rows: command kind and cycles ready stays low after the take
    logic [1:0] row_t [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
    int row_g [4] = '{2, 2, 4, 11};

    always #25 mclk_i = ~mclk_i;

    lp4_pd_sequencer i_lp4_pd_sequencer (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .pd_req_i(pd_req_i), .cmd_valid_i(cmd_valid_i), .cmd_type_i(cmd_type_i),
        .cmd_ready_o(cmd_ready_o), .pd_active_o(pd_active_o), .cke_o(cke_o), .cs_o(cs_o),
        .cs_oe_o(cs_oe_o), .ck_run_o(ck_run_o), .cmd_o(cmd_o));
    lp4_pd_device_model i_lp4_pd_device_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .cke_i(cke_o), .cs_i(cs_o), .cs_oe_i(cs_oe_o), .ck_run_i(ck_run_o), .cmd_i(cmd_o),
        .strobe_drv_o(strobe_drv), .err_o(dev_err));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Counts falling edges until the chosen output reaches lvl; bounded
    task automatic wait_sig(input int sel, input logic lvl, output int cnt);
        logic v;
        for (cnt = 0; cnt < 200; cnt++) begin
            v = (sel == 0) ? cke_o : (sel == 1) ? ck_run_o : (sel == 2) ? cmd_ready_o : cs_o;
            if (v === lvl)
                return;
            @(negedge mclk_i);
        end
        n_fail++;
        $display("unexpected at %0t: wait ran out", $time);
        wrap_up();
    endtask

    // Holds the request until the taking edge, then checks the select and command outputs
    task automatic issue(input logic [1:0] t);
        cmd_valid_i = 1'b1;
        cmd_type_i = t;
        wait_sig(2, 1'b1, n);
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        check(cs_o, 1);
        check(cmd_o, t);
    endtask

    initial begin
        repeat (12) @(negedge mclk_i);
        check({cke_o, cs_o, cs_oe_o, ck_run_o, cmd_ready_o, pd_active_o}, 8'h2C);
        rst_n_i = 1'b1;
        // Every command kind, spacing measured after each
        for (int i = 0; i < 4; i++) begin
            issue(row_t[i]);
            wait_sig(2, 1'b1, n);
            check(n, row_g[i]);
            check(strobe_drv, row_t[i] == 2'h1);
            $display("row %0d done", i);
        end
        // Entry right after a mode write: long hold; a command waits meanwhile
        pd_req_i = 1'b1;
        @(negedge mclk_i);
        // Held command is an ordinary one, raised only after ready has dropped
        cmd_valid_i = 1'b1;
        cmd_type_i = 2'h0;
        wait_sig(0, 1'b0, n);
        check(cs_oe_o, 1);
        wait_sig(1, 1'b0, n);
        check(n, 11);
        check({pd_active_o, cs_oe_o, cs_o}, 8'h4);
        repeat (6) @(negedge mclk_i);
        check(cs_o, 0);
        // Exit: clock back first, then enable, then the held command
        pd_req_i = 1'b0;
        wait_sig(1, 1'b1, n);
        check(cs_oe_o, 1);
        wait_sig(0, 1'b1, n);
        check(n, 4);
        wait_sig(3, 1'b1, n);
        cmd_valid_i = 1'b0;
        check(n >= 12, 1);
        check(cmd_o, 2'h0);
        $display("mode write entry and exit done");
        // Plain entry after an ordinary command: short hold
        @(negedge mclk_i);
        pd_req_i = 1'b1;
        wait_sig(0, 1'b0, n);
        wait_sig(1, 1'b0, n);
        check(n, 6);
        check(dev_err, 0);
        $display("plain entry done");
        // Reset while in power-down wakes the pins at once
        rst_n_i = 1'b0;
        pd_req_i = 1'b0;
        #5;
        check({cke_o, cs_o, ck_run_o, pd_active_o}, 8'hA);
        repeat (3) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        // Awake with clock running and ready again after the release
        check({cke_o, ck_run_o, cmd_ready_o, pd_active_o}, 8'hE);
        check(dev_err, 0);
        $display("reset in power-down done");
        wrap_up();
    end
endmodule // dram_powerdown_mode_reg_timing_tb
